// ==== design/power_gate_pkg.sv ====
package power_gate_pkg;
  localparam int unsigned DATA_W         = 12;
  localparam int unsigned CLOCK_HZ       = 20_000_000;
  localparam int unsigned NAP_CYCLES     = 100;
  localparam int unsigned SLEEP_WAIT_US  = 2000;
  localparam int unsigned SLEEP_CYCLES   = SLEEP_WAIT_US * (CLOCK_HZ / 1_000_000);
  localparam int unsigned CNT_W          = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE   = 16'h0001;
  localparam logic [DATA_W-1:0] DATA_ZERO = 12'h000;

  typedef enum logic [3:0] {
    ST_NORMAL  = 4'b0001,
    ST_SLEEP   = 4'b0010,
    ST_NAP     = 4'b0100,
    ST_RECOVER = 4'b1000
  } power_state_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              overrange_flag;
  } sample_t;

  typedef struct packed {
    sample_t value;
    logic    data_oe;
    logic    sample_clock_out;
    logic    clock_oe;
  } pad_out_t;
endpackage : power_gate_pkg

// ==== design/output_pad_stage.sv ====
`timescale 1ns/100ps
module output_pad_stage (
  input  wire logic                      clock,
  input  wire logic                      rst,
  input  wire power_gate_pkg::sample_t   sample_in,
  input  wire logic                      drive_en,
  input  wire logic                      clock_phase,
  output      power_gate_pkg::pad_out_t  pads
);
  import power_gate_pkg::*;

  typedef struct packed {
    pad_out_t out;
  } pad_state_t;

  pad_state_t state_reg;
  pad_state_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.out.value            = sample_in;
    state_next.out.data_oe          = drive_en;
    state_next.out.clock_oe         = drive_en;
    state_next.out.sample_clock_out = clock_phase;
    if (!drive_en) begin
      state_next.out.value.data           = DATA_ZERO;
      state_next.out.value.overrange_flag = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pads = state_reg.out;
endmodule : output_pad_stage

// ==== design/power_mode_gate.sv ====
`timescale 1ns/100ps
module power_mode_gate #(
  parameter int unsigned SLEEP_WAIT = power_gate_pkg::SLEEP_CYCLES
) (
  input  wire logic                      clock,
  input  wire logic                      rst,
  input  wire logic                      power_down_select,
  input  wire logic                      output_disable,
  input  wire power_gate_pkg::sample_t   sample_in,
  output      power_gate_pkg::pad_out_t  pads,
  output      logic                      data_valid,
  output      logic                      reference_on,
  output      logic                      converter_on
);
  import power_gate_pkg::*;

  typedef struct packed {
    power_state_t     mode;
    logic [CNT_W-1:0] wait_cnt;
    logic             valid;
    logic             ref_on;
    logic             conv_on;
    logic             phase;
    logic             drive;
  } ctrl_state_t;

  ctrl_state_t state_reg;
  ctrl_state_t state_next;

  always_comb begin
    state_next = state_reg;
    // Divided phase toggles every encode edge so the copy stays registered
    state_next.phase = ~state_reg.phase;
    unique case (state_reg.mode)
      ST_NORMAL: begin
        if (power_down_select) begin
          state_next.mode = output_disable ? ST_SLEEP : ST_NAP;
        end
      end
      ST_SLEEP: begin
        if (!power_down_select) begin
          state_next.mode     = ST_RECOVER;
          state_next.wait_cnt = CNT_W'(SLEEP_WAIT);
        end else if (!output_disable) begin
          state_next.mode = ST_NAP;
        end
      end
      ST_NAP: begin
        if (!power_down_select) begin
          state_next.mode     = ST_RECOVER;
          state_next.wait_cnt = CNT_W'(NAP_CYCLES);
        end else if (output_disable) begin
          state_next.mode = ST_SLEEP;
        end
      end
      ST_RECOVER: begin
        if (power_down_select) begin
          state_next.mode = output_disable ? ST_SLEEP : ST_NAP;
        end else if (state_reg.wait_cnt <= CNT_ONE) begin
          state_next.mode     = ST_NORMAL;
          state_next.wait_cnt = CNT_ZERO;
        end else begin
          state_next.wait_cnt = state_reg.wait_cnt - CNT_ONE;
        end
      end
      default: begin
        state_next.mode = ST_NORMAL;
      end
    endcase
    state_next.valid   = (state_next.mode == ST_NORMAL);
    state_next.conv_on = (state_next.mode != ST_SLEEP)
                       && (state_next.mode != ST_NAP);
    state_next.ref_on  = (state_next.mode != ST_SLEEP);
    // Recovery still drives pins; only data_valid marks the samples bad
    state_next.drive   = !output_disable
                       && !power_down_select;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= '{mode: ST_NORMAL, wait_cnt: CNT_ZERO, valid: 1'b1,
                     ref_on: 1'b1, conv_on: 1'b1, phase: 1'b0,
                     drive: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  output_pad_stage pad_stage (
    .clock       (clock),
    .rst         (rst),
    .sample_in   (sample_in),
    .drive_en    (state_reg.drive),
    .clock_phase (state_reg.phase),
    .pads        (pads)
  );

  assign data_valid   = state_reg.valid;
  assign reference_on = state_reg.ref_on;
  assign converter_on = state_reg.conv_on;
endmodule : power_mode_gate

// ==== testbench/power_mode_gate_properties.sv ====
`timescale 1ns/100ps
module power_mode_gate_properties #(parameter int SLEEP_WAIT = 5) (
  input logic                     clock,
  input logic                     rst,
  input logic                     power_down_select,
  input logic                     output_disable,
  input logic                     data_valid,
  input logic                     reference_on,
  input logic                     converter_on,
  input power_gate_pkg::pad_out_t pads
);
  localparam int LO = SLEEP_WAIT - 2;
  localparam int HI = SLEEP_WAIT + 2;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_od_hiz: assert property (output_disable[*2] |=>
    !pads.data_oe && !pads.clock_oe) else $error("od");
  chk_normal_drive: assert property (
    (!power_down_select && !output_disable)[*2] |=> pads.data_oe)
    else $error("drive");
  chk_down_hiz: assert property (power_down_select[*2] |=>
    !pads.data_oe && !pads.clock_oe) else $error("down");
  chk_sleep_off: assert property (power_down_select &&
    output_disable |=> !reference_on && !converter_on) else $error("sleep");
  chk_nap_ref: assert property (power_down_select &&
    !output_disable |=> reference_on && !converter_on) else $error("nap");
  chk_nap_wait: assert property ((power_down_select &&
    !output_disable) ##1 !power_down_select |-> ##98 !data_valid
    ##[1:4] data_valid) else $error("nap wait");
  chk_sleep_wait: assert property ((power_down_select &&
    output_disable) ##1 !power_down_select |-> !data_valid
    ##[LO:HI] data_valid) else $error("sleep wait");
  chk_clock_copy: assert property (pads.clock_oe[*2] |->
    pads.sample_clock_out != $past(pads.sample_clock_out)) else $error("clk");
endmodule : power_mode_gate_properties
bind power_mode_gate power_mode_gate_properties
  #(.SLEEP_WAIT(SLEEP_WAIT)) chk_u (.*);

// ==== testbench/host_capture.sv ====
`timescale 1ns/100ps
module host_capture (
  input  logic                      clock,
  input  power_gate_pkg::pad_out_t  pads,
  input  logic                      data_valid,
  output power_gate_pkg::sample_t   got
);
  // Captures only while driven and valid; never gates pins at speed
  always @(posedge clock) if (pads.data_oe && data_valid) got <= pads.value;
endmodule : host_capture

// ==== testbench/power_mode_gate_tb.sv ====
`timescale 1ns/100ps
module power_mode_gate_tb;
  import power_gate_pkg::*;
  localparam int unsigned SW = 5;
  logic     clock = 0, rst = 1, pds = 0, od = 0, dv, ref_on, c, conv;
  sample_t  sin = '{12'ha5c, 1'b1}, got;
  pad_out_t pads;
  int       errors = 0, n_checks = 0;
`define CK(n, e, s) begin n_checks++; if ((s) !== (e)) begin errors++; \
  $display("BAD %s exp %h seen %h", n, e, s); end end
  initial forever #25 clock = ~clock;
  power_mode_gate #(.SLEEP_WAIT(SW)) dut_u (.clock(clock), .rst(rst),
    .power_down_select(pds), .output_disable(od), .sample_in(sin),
    .pads(pads), .data_valid(dv), .reference_on(ref_on),
    .converter_on(conv));
  host_capture host_u (.clock(clock), .pads(pads), .data_valid(dv),
    .got(got));
  task step(input int n, input logic p, input logic d);
    pds = p;
    od = d;
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  task t_normal;
    step(4, 0, 0);
    `CK("host", sin, got)
    `CK("conv", 1'b1, conv)
    c = pads.sample_clock_out;
    step(1, 0, 0);
    `CK("sample_clock_out", ~c, pads.sample_clock_out)
  endtask : t_normal
  task t_disable;
    // Held for a long idle span, not toggled at sample rate
    step(20, 0, 1);
    `CK("oe", 1'b0, pads.data_oe)
    `CK("clk oe", 1'b0, pads.clock_oe)
  endtask : t_disable
  task t_nap;
    step(3, 1, 0);
    `CK("valid", 1'b0, dv)
    `CK("ref", 1'b1, ref_on)
    `CK("conv", 1'b0, conv)
    `CK("oe", 1'b0, pads.data_oe)
    step(NAP_CYCLES, 0, 0);
    `CK("valid", 1'b0, dv)
    step(1, 0, 0);
    `CK("valid", 1'b1, dv)
  endtask : t_nap
  task t_sleep;
    step(3, 1, 1);
    `CK("ref", 1'b0, ref_on)
    `CK("conv", 1'b0, conv)
    `CK("clk oe", 1'b0, pads.clock_oe)
    `CK("valid", 1'b0, dv)
    step(SW, 0, 0);
    `CK("valid", 1'b0, dv)
    step(1, 0, 0);
    `CK("valid", 1'b1, dv)
  endtask : t_sleep
  task report_and_stop;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    // Roughly thirteen times the expected run
    #100us;
    errors++;
    report_and_stop;
  end
  initial begin
    repeat (16) @(posedge clock);
    #1 rst = 0;
    t_normal;
    t_disable;
    t_nap;
    t_sleep;
    report_and_stop;
  end
endmodule : power_mode_gate_tb
